// file: rtl/esrd_pkg.sv
// Constants and types shared by the event input, set point ramp and dwell block.
package esrd_pkg;
    localparam int DW = 16;
    localparam int AW = 4;
    // Register word addresses.
    localparam logic [3:0] A_CONFIG = 4'h0;
    localparam logic [3:0] A_SP1    = 4'h1;
    localparam logic [3:0] A_SP2    = 4'h2;
    localparam logic [3:0] A_RATE   = 4'h3;
    localparam logic [3:0] A_DWELL  = 4'h4;
    localparam logic [3:0] A_GAIN0  = 4'h5;
    localparam logic [3:0] A_STATUS = 4'hb;
    localparam logic [3:0] A_WORK   = 4'hc;
    localparam logic [15:0] CONFIG_RST = 16'h0000;
    // Configuration field positions.
    localparam int C_FUNC = 0;
    localparam int C_FMT  = 4;
    localparam int C_SRC  = 5;
    localparam int C_A1DW = 7;
    localparam int C_A2DW = 8;
    // Event function codes.
    localparam logic [3:0] F_NONE  = 4'h0;
    localparam logic [3:0] F_SP2   = 4'h1;
    localparam logic [3:0] F_GAIN  = 4'h2;
    localparam logic [3:0] F_BOTH  = 4'h3;
    localparam logic [3:0] F_CLR1  = 4'h4;
    localparam logic [3:0] F_CLR2  = 4'h5;
    localparam logic [3:0] F_CLR12 = 4'h6;
    localparam logic [3:0] F_DIS1  = 4'h7;
    localparam logic [3:0] F_DIS2  = 4'h8;
    localparam logic [3:0] F_DIS12 = 4'h9;
    localparam logic [3:0] F_LOCK  = 4'ha;
    // Set point sources.
    localparam logic [1:0] S_SINGLE = 2'h0;
    localparam logic [1:0] S_DUAL   = 2'h1;
    localparam logic [1:0] S_MIN    = 2'h2;
    localparam logic [1:0] S_HOUR   = 2'h3;
    // Timing.
    localparam int CLK_MHZ = 10;
    localparam int DEBOUNCE_US = 10000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
    localparam int MS_US = 1000;
    localparam int MS_CYCLES = MS_US * CLK_MHZ;
    localparam int DWELL_TICK_MS = 6000;
    localparam logic [22:0] MIN_MS  = 23'h00ea60;
    localparam logic [22:0] HOUR_MS = 23'h36ee80;
    typedef enum logic [2:0] {
        DW_IDLE = 3'b001,
        DW_RUN  = 3'b010,
        DW_DONE = 3'b100
    } dwell_e;
endpackage

// file: rtl/event_input_setpoint_ramp_dwell.sv
// Event input decode, second set point, set point ramp and dwell timer.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module event_input_setpoint_ramp_dwell #(
    parameter int DEBOUNCE_CYC = esrd_pkg::DEBOUNCE_CYCLES,
    parameter int MS_CYC       = esrd_pkg::MS_CYCLES,
    parameter int TICK_MS      = esrd_pkg::DWELL_TICK_MS
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        event_in,
    input  wire logic [15:0] process_value,
    input  wire logic [15:0] mv1_computed,
    input  wire logic [15:0] mv2_computed,
    input  wire logic        alarm1_condition,
    input  wire logic        alarm2_condition,
    input  wire logic        tune_done,
    input  wire logic [15:0] tuned_pb,
    input  wire logic [15:0] tuned_ti,
    input  wire logic [15:0] tuned_td,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [15:0] rd_data,
    output logic      [15:0] output1_drive_level,
    output logic      [15:0] output2_drive_level,
    output logic             alarm1_out,
    output logic             alarm2_out,
    output logic      [15:0] working_setpoint,
    output logic      [15:0] active_pb,
    output logic      [15:0] active_ti,
    output logic      [15:0] active_td,
    output logic             config_error
);
    localparam int DBW = $clog2(DEBOUNCE_CYC + 1);
    localparam int MSW = $clog2(MS_CYC + 1);
    localparam int TKW = $clog2(TICK_MS + 1);

    // Counters below one cycle or with no width cannot work.
    if (DEBOUNCE_CYC < 2 || MS_CYC < 2 || TICK_MS < 2) begin : g_chk
        $error("Timing parameters must be at least 2.");
    end

    // Register state.
    logic [15:0] config_r;
    logic [15:0] sp1_r;
    logic [15:0] sp2_r;
    logic [15:0] rate_r;
    logic [15:0] dwell_r;
    logic [15:0] gain_r [0:5];
    logic        rej_r;

    // Three-stage synchroniser and debounce for the event pin.
    logic           ev_s1_r;
    logic           ev_s2_r;
    logic           ev_s3_r;
    logic           ev_r;
    logic [DBW-1:0] db_cnt_r;
    wire            db_diff = (ev_s2_r == ev_s3_r) && (ev_s3_r != ev_r);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ev_s1_r  <= 1'b0;
            ev_s2_r  <= 1'b0;
            ev_s3_r  <= 1'b0;
            ev_r     <= 1'b0;
            db_cnt_r <= '0;
        end else begin
            ev_s1_r <= event_in;
            ev_s2_r <= ev_s1_r;
            ev_s3_r <= ev_s2_r;
            if (!db_diff) begin
                db_cnt_r <= '0;
            end else if (db_cnt_r == DBW'(DEBOUNCE_CYC - 1)) begin
                ev_r     <= ev_s3_r;
                db_cnt_r <= '0;
            end else begin
                db_cnt_r <= db_cnt_r + 1'b1;
            end
        end
    end

    // Event function decode; unknown codes behave as no function.
    wire [3:0] func  = config_r[esrd_pkg::C_FUNC +: 4];
    wire       fmt   = config_r[esrd_pkg::C_FMT];
    wire [1:0] src   = config_r[esrd_pkg::C_SRC +: 2];
    wire       a1dw  = config_r[esrd_pkg::C_A1DW];
    wire       a2dw  = config_r[esrd_pkg::C_A2DW];

    function automatic logic ev_is(input logic [3:0] f, input logic [3:0] a,
                                   input logic [3:0] b);
        ev_is = (f == a) || (f == b);
    endfunction

    wire alt_sp   = ev_r && ev_is(func, esrd_pkg::F_SP2, esrd_pkg::F_BOTH)
                    && (src != esrd_pkg::S_SINGLE);
    wire alt_gain = ev_r && ev_is(func, esrd_pkg::F_GAIN, esrd_pkg::F_BOTH);
    wire clr1     = ev_r && ev_is(func, esrd_pkg::F_CLR1, esrd_pkg::F_CLR12);
    wire clr2     = ev_r && ev_is(func, esrd_pkg::F_CLR2, esrd_pkg::F_CLR12);
    wire dis1     = ev_r && ev_is(func, esrd_pkg::F_DIS1, esrd_pkg::F_DIS12);
    wire dis2     = ev_r && ev_is(func, esrd_pkg::F_DIS2, esrd_pkg::F_DIS12);
    wire locked   = ev_r && (func == esrd_pkg::F_LOCK);
    wire wr_ok    = wr_en && !locked;

    // Second set point: absolute or offset from the primary.
    wire [15:0] sp2_eff = fmt ? 16'(sp1_r + sp2_r) : sp2_r;
    wire [15:0] target  = alt_sp ? sp2_eff : sp1_r;

    // Register writes; a locked write is dropped and remembered.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            config_r <= esrd_pkg::CONFIG_RST;
            sp1_r    <= '0;
            sp2_r    <= '0;
            rate_r   <= '0;
            dwell_r  <= '0;
            rej_r    <= 1'b0;
        end else begin
            if (wr_ok && addr == esrd_pkg::A_CONFIG) config_r <= wr_data;
            if (wr_ok && addr == esrd_pkg::A_SP1) sp1_r <= wr_data;
            if (wr_ok && addr == esrd_pkg::A_SP2) sp2_r <= wr_data;
            if (wr_ok && addr == esrd_pkg::A_RATE) rate_r <= wr_data;
            if (wr_ok && addr == esrd_pkg::A_DWELL) dwell_r <= wr_data;
            // A new rejection beats a status read in the same cycle.
            if (wr_en && locked) rej_r <= 1'b1;
            else if (rd_en && addr == esrd_pkg::A_STATUS) rej_r <= 1'b0;
        end
    end

    // Gain sets; a finished tune overrides a bus write to the same set.
    wire [15:0] tuned_w [0:2];
    assign tuned_w[0] = tuned_pb;
    assign tuned_w[1] = tuned_ti;
    assign tuned_w[2] = tuned_td;

    for (genvar i = 0; i < 6; i++) begin : g_gain
        wire tune_hit = tune_done && ((i >= 3) == alt_gain);
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                gain_r[i] <= '0;
            end else if (tune_hit) begin
                gain_r[i] <= tuned_w[i % 3];
            end else if (wr_ok && addr == 4'(esrd_pkg::A_GAIN0 + i)) begin
                gain_r[i] <= wr_data;
            end
        end
    end

    // Millisecond tick shared by ramp and dwell.
    logic [MSW-1:0] ms_cnt_r;
    wire            ms_tick = (ms_cnt_r == MSW'(MS_CYC - 1));

    always_ff @(posedge sys_clk) begin
        if (!rst_n) ms_cnt_r <= '0;
        else ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
    end

    // Ramp: one count per accumulator overflow, so rates above one
    // count per millisecond are capped there.
    logic [15:0] ramp_r;
    logic [22:0] acc_r;
    logic [15:0] tgt_prev_r;
    logic        init_r;
    wire         ramp_src = (src == esrd_pkg::S_MIN) || (src == esrd_pkg::S_HOUR);
    wire         ramp_on  = ramp_src && (rate_r != '0);
    wire [22:0]  div      = (src == esrd_pkg::S_HOUR) ? esrd_pkg::HOUR_MS
                                                      : esrd_pkg::MIN_MS;
    wire [22:0]  acc_sum  = acc_r + {7'h00, rate_r};
    wire         step     = acc_sum >= div;
    wire         reload   = init_r || (target != tgt_prev_r)
                            || (wr_ok && addr == esrd_pkg::A_RATE);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ramp_r     <= '0;
            acc_r      <= '0;
            tgt_prev_r <= '0;
            init_r     <= 1'b1;
        end else begin
            tgt_prev_r <= target;
            init_r     <= 1'b0;
            if (reload) begin
                ramp_r <= process_value;
                acc_r  <= '0;
            end else if (ramp_on && ms_tick) begin
                acc_r <= step ? acc_sum - div : acc_sum;
                if (step && ramp_r < target) ramp_r <= ramp_r + 1'b1;
                else if (step && ramp_r > target) ramp_r <= ramp_r - 1'b1;
            end
        end
    end

    wire [15:0] work = ramp_on ? ramp_r : target;

    // Dwell timer; alarm 1 owns it when both channels ask for it.
    esrd_pkg::dwell_e dw_state_r;
    logic [TKW-1:0]   tk_cnt_r;
    logic [15:0]      dw_cnt_r;
    logic             above_r;
    wire              dw_en    = a1dw || a2dw;
    wire              dw_clr   = a1dw ? clr1 : clr2;
    wire              reached  = (process_value == work)
                                 || ((process_value > work) != above_r);
    wire              tenth    = ms_tick && (tk_cnt_r == TKW'(TICK_MS - 1));
    wire              dw_done  = (dw_state_r == esrd_pkg::DW_DONE);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dw_state_r <= esrd_pkg::DW_IDLE;
            tk_cnt_r   <= '0;
            dw_cnt_r   <= '0;
            above_r    <= 1'b0;
        end else begin
            above_r <= process_value > work;
            if (ms_tick) tk_cnt_r <= tenth ? '0 : tk_cnt_r + 1'b1;
            case (dw_state_r)
                esrd_pkg::DW_IDLE: begin
                    dw_cnt_r <= '0;
                    if (dw_en && !dw_clr && reached) begin
                        dw_state_r <= esrd_pkg::DW_RUN;
                    end
                end
                esrd_pkg::DW_RUN: begin
                    if (!dw_en || dw_clr) begin
                        dw_state_r <= esrd_pkg::DW_IDLE;
                    end else if (dw_cnt_r >= dwell_r) begin
                        dw_state_r <= esrd_pkg::DW_DONE;
                    end else if (tenth) begin
                        dw_cnt_r <= dw_cnt_r + 1'b1;
                    end
                end
                esrd_pkg::DW_DONE: begin
                    if (!dw_en || dw_clr) dw_state_r <= esrd_pkg::DW_IDLE;
                end
                default: dw_state_r <= esrd_pkg::DW_IDLE;
            endcase
        end
    end

    // Alarms latch; a held reset wins, and a persisting cause
    // sets the alarm again the cycle after release.
    wire set1 = a1dw ? dw_done : alarm1_condition;
    wire set2 = a2dw ? (dw_done && !a1dw) : alarm2_condition;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            alarm1_out <= 1'b0;
            alarm2_out <= 1'b0;
            config_error <= 1'b0;
        end else begin
            alarm1_out   <= !clr1 && (alarm1_out || set1);
            alarm2_out   <= !clr2 && (alarm2_out || set2);
            config_error <= a1dw && a2dw;
        end
    end

    // Outputs to the drive stage and the controller core.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            output1_drive_level <= '0;
            output2_drive_level <= '0;
            working_setpoint    <= '0;
            active_pb           <= '0;
            active_ti           <= '0;
            active_td           <= '0;
        end else begin
            output1_drive_level <= dis1 ? '0 : mv1_computed;
            output2_drive_level <= dis2 ? '0 : mv2_computed;
            working_setpoint    <= work;
            active_pb           <= alt_gain ? gain_r[3] : gain_r[0];
            active_ti           <= alt_gain ? gain_r[4] : gain_r[1];
            active_td           <= alt_gain ? gain_r[5] : gain_r[2];
        end
    end

    // Read path; data stand for exactly the cycle after the strobe.
    wire [15:0] status = {7'h00, alt_gain, ramp_on, rej_r, locked,
                          dw_state_r == esrd_pkg::DW_RUN, config_error,
                          alarm2_out, alarm1_out, ev_r};
    logic [15:0] rd_mux;

    always_comb begin
        case (addr)
            esrd_pkg::A_CONFIG: rd_mux = config_r;
            esrd_pkg::A_SP1:    rd_mux = sp1_r;
            esrd_pkg::A_SP2:    rd_mux = sp2_r;
            esrd_pkg::A_RATE:   rd_mux = rate_r;
            esrd_pkg::A_DWELL:  rd_mux = dwell_r;
            esrd_pkg::A_STATUS: rd_mux = status;
            esrd_pkg::A_WORK:   rd_mux = work;
            default: begin
                if (addr >= esrd_pkg::A_GAIN0 && addr < esrd_pkg::A_STATUS) begin
                    rd_mux = gain_r[3'(addr - esrd_pkg::A_GAIN0)];
                end else begin
                    rd_mux = '0;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) rd_data <= '0;
        else rd_data <= rd_en ? rd_mux : '0;
    end

    // Checks on the decoded behaviour.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_OUT1_OFF: assert property (ev_r && func == esrd_pkg::F_DIS1
        |=> output1_drive_level == '0) else $error("Output 1 not forced off.");
    AST_OUT2_OFF: assert property (ev_r && func == esrd_pkg::F_DIS2
        |=> output2_drive_level == '0) else $error("Output 2 not forced off.");
    AST_BOTH_OFF: assert property ($rose(ev_r) && func == esrd_pkg::F_DIS12
        |=> output1_drive_level == '0 && output2_drive_level == '0)
        else $error("Outputs not cleared at event.");
    AST_RESTORE: assert property ($fell(ev_r) && func == esrd_pkg::F_DIS12
        |=> output1_drive_level == $past(mv1_computed))
        else $error("Output 1 not restored on release.");
    AST_LOCK: assert property (locked && wr_en
        |=> $stable(config_r) && $stable(sp1_r) && $stable(dwell_r) && rej_r)
        else $error("Write taken while locked.");
    AST_OFFSET: assert property (alt_sp && fmt
        |=> working_setpoint == 16'($past(sp1_r) + $past(sp2_r)) || $past(ramp_on))
        else $error("Offset second set point wrong.");
    AST_SP_SINGLE: assert property (src == esrd_pkg::S_SINGLE
        |-> target == sp1_r) else $error("Secondary used in single source.");
    AST_NONE_GAIN: assert property (func == esrd_pkg::F_NONE ##1 1'b1
        |-> active_pb == $past(gain_r[0])) else $error("Alternate gain with no function.");
    AST_CLR1: assert property (clr1 |=> !alarm1_out [*1] ##0 1'b1)
        else $error("Alarm 1 not cleared.");
    AST_RETRIG: assert property ($fell(clr1) && alarm1_condition && !a1dw
        |=> alarm1_out) else $error("Alarm 1 not retriggered.");
    AST_DWELL_HOLD: assert property (a1dw && alarm1_out && !clr1
        |=> alarm1_out) else $error("Dwell alarm dropped.");
    AST_CFG_ERR: assert property (a1dw && a2dw ##1 a1dw && a2dw
        |-> config_error) else $error("Configuration error not flagged.");
    AST_DEBOUNCE: assert property ($changed(ev_r)
        |-> $past(ev_s2_r) == $past(ev_s3_r)) else $error("Event changed unfiltered.");

    // Checks on the second alarm, second set point, gain selection, ramp, dwell and read paths.
    AST_CLR2: assert property (clr2 |=> !alarm2_out)
        else $error("Alarm 2 not cleared.");
    AST_RETRIG2: assert property ($fell(clr2) && alarm2_condition && !a2dw
        |=> alarm2_out) else $error("Alarm 2 not retriggered.");
    AST_SP2_ABS: assert property (alt_sp && !fmt && !ramp_on
        |=> working_setpoint == $past(sp2_r)) else $error("Second set point wrong.");
    AST_ALT_GAIN: assert property (alt_gain
        |=> active_pb == $past(gain_r[3]) && active_td == $past(gain_r[5]))
        else $error("Second gain set not used.");
    AST_TUNE_ALT: assert property (tune_done && alt_gain
        |=> gain_r[3] == $past(tuned_pb)) else $error("Tune missed second set.");
    AST_TUNE_PRI: assert property (tune_done && !alt_gain
        |=> gain_r[0] == $past(tuned_pb)) else $error("Tune missed first set.");
    AST_RAMP_LOAD: assert property (reload
        |=> ramp_r == $past(process_value)) else $error("Ramp not loaded.");
    AST_RAMP_ZERO: assert property (ramp_src && rate_r == '0
        |=> working_setpoint == $past(target)) else $error("Zero rate still ramps.");
    AST_RAMP_STEP: assert property (ramp_on && !reload && !ms_tick
        |=> $stable(ramp_r)) else $error("Ramp moved off its tick.");
    AST_DWELL_END: assert property (dw_state_r == esrd_pkg::DW_RUN && dw_en && !dw_clr
        && dw_cnt_r >= dwell_r |=> dw_done) else $error("Dwell did not expire.");
    AST_RD_IDLE: assert property (!rd_en
        |=> rd_data == '0) else $error("Read data without a strobe.");

    COV_SP2: cover property (alt_sp && !fmt);
    COV_TUNE_ALT: cover property (tune_done && alt_gain);
    COV_DWELL: cover property (dw_done ##1 dw_clr);
    COV_LOCK: cover property (locked && wr_en);
    COV_HOUR: cover property (ramp_on && src == esrd_pkg::S_HOUR && ms_tick);
endmodule

// file: tb/event_source.sv
// Behavioural event contact that chatters on every change before it settles.
`timescale 1ns/10ps
module event_source #(
    parameter int BOUNCES = 3
) (
    input  wire logic want,
    input  wire logic bouncy,
    output logic      event_in
);
    // Each chatter pulse is shorter than the filter window, so only the settled level counts.
    initial event_in = 1'b0;
    always @(want) begin
        if (bouncy) begin
            for (int i = 0; i < BOUNCES; i++) begin
                event_in = want;
                #130;
                event_in = !want;
                #180;
            end
        end
        event_in = want;
    end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the event input, set point ramp and dwell block.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
end
module testbench;
    typedef struct { string nm; int sel; logic [15:0] exp; } note_s;
    logic        sys_clk, rst_n, want, bouncy, event_in, c1, c2, tune, wr_en, rd_en;
    logic        a1, a2, cerr, rd_v;
    logic [3:0]  addr;
    logic [15:0] pv, mv1, mv2, tpb, tti, ttd, wr_data, rd_data, o1, o2, work, apb, ati, atd;
    logic [15:0] sp1, sp2, pb1, pb2;
    int          failures, comparisons;
    note_s       q[$];

    event_source src (.want(want), .bouncy(bouncy), .event_in(event_in));
    event_input_setpoint_ramp_dwell #(.DEBOUNCE_CYC(4), .MS_CYC(4), .TICK_MS(2)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .event_in(event_in), .process_value(pv),
        .mv1_computed(mv1), .mv2_computed(mv2), .alarm1_condition(c1), .alarm2_condition(c2),
        .tune_done(tune), .tuned_pb(tpb), .tuned_ti(tti), .tuned_td(ttd), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .output1_drive_level(o1), .output2_drive_level(o2), .alarm1_out(a1), .alarm2_out(a2),
        .working_setpoint(work), .active_pb(apb), .active_ti(ati), .active_td(atd),
        .config_error(cerr));

    // The clock runs at 10 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Read data only stand in the cycle after the strobe, so remember when that is.
    always @(posedge sys_clk) rd_v <= rd_en;

    // Notes are compared in mid cycle, when every output has settled.
    always @(negedge sys_clk) begin
        while (q.size() > 0 && (q[0].sel != 0 || rd_v)) begin
            note_s n;
            logic [15:0] got;
            n = q.pop_front();
            case (n.sel)
                0: got = rd_data;
                1: got = o1;
                2: got = o2;
                3: got = {14'h0, a2, a1};
                4: got = work;
                5: got = apb;
                8: got = {15'h0, cerr};
                default: got = {15'h0, work > 16'h0200 && work < 16'h0400};
            endcase
            `CHK(n.nm, n.exp, got)
            if (n.sel == 0) begin
                break;
            end
        end
    end

    function automatic logic [15:0] cfg(input logic [3:0] f, input logic fmt,
                                        input logic [1:0] s, input logic d1, input logic d2);
        return 16'({d2, d1, s, fmt, f});
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
        @(posedge sys_clk);
        rd_en <= 1'b1;
        addr <= a;
        q.push_back('{nm, 0, e});
        @(posedge sys_clk);
        rd_en <= 1'b0;
    endtask

    task automatic look(input int sel, input logic [15:0] e, input string nm);
        q.push_back('{nm, sel, e});
        @(negedge sys_clk);
        @(posedge sys_clk);
    endtask

    // The filter needs its window plus the chatter time; this leaves a margin.
    task automatic ev(input logic lvl);
        @(posedge sys_clk);
        want <= lvl;
        cyc(24);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog, far beyond the roughly 1250 cycles the tests need.
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("watchdog expired");
        wrap_up();
    end

    initial begin
        {rst_n, want, bouncy, c1, c2, tune, wr_en, rd_en, addr} = '0;
        {pv, tpb, tti, ttd, wr_data} = '0;
        failures = 0;
        comparisons = 0;
        void'($urandom(47452));
        mv1 = {1'b1, 15'($urandom)};
        mv2 = {1'b1, 15'($urandom)};
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(esrd_pkg::A_CONFIG, esrd_pkg::CONFIG_RST, "config");
        rd(4'hd, 16'h0, "unmapped");
        look(1, mv1, "out1 after reset");
        $display("test reset done");

        // Every function code, with both alarm causes present throughout.
        sp1 = 16'($urandom_range(16'h7fff));
        sp2 = 16'($urandom_range(16'h7fff));
        pb1 = 16'($urandom);
        pb2 = ~pb1;
        bouncy <= 1'b1;
        c1 <= 1'b1;
        c2 <= 1'b1;
        wr(esrd_pkg::A_SP1, sp1);
        wr(esrd_pkg::A_SP2, sp2);
        wr(esrd_pkg::A_GAIN0, pb1);
        wr(4'(esrd_pkg::A_GAIN0 + 4'h3), pb2);
        for (int f = 0; f <= 10; f++) begin
            wr(esrd_pkg::A_CONFIG, cfg(4'(f), 1'b0, esrd_pkg::S_DUAL, 1'b0, 1'b0));
            ev(1'b1);
            look(1, (f == 7 || f == 9) ? 16'h0 : mv1, "out1 active");
            look(2, (f == 8 || f == 9) ? 16'h0 : mv2, "out2 active");
            look(3, {14'h0, !(f == 5 || f == 6), !(f == 4 || f == 6)}, "alarms on");
            look(4, (f == 1 || f == 3) ? sp2 : sp1, "set point active");
            look(5, (f == 2 || f == 3) ? pb2 : pb1, "band active");
            if (f == 10) begin
                wr(esrd_pkg::A_SP1, ~sp1);
                rd(esrd_pkg::A_SP1, sp1, "locked set point");
                rd(esrd_pkg::A_STATUS, 16'h0067, "status locked");
                rd(esrd_pkg::A_STATUS, 16'h0027, "status reject read");
            end
            ev(1'b0);
            look(1, mv1, "out1 released");
            look(2, mv2, "out2 released");
            look(3, 16'h3, "alarms retriggered");
        end
        $display("test function codes done");

        // Offset format, then a source that must not honour the second set point.
        wr(esrd_pkg::A_CONFIG, cfg(esrd_pkg::F_SP2, 1'b1, esrd_pkg::S_DUAL, 1'b0, 1'b0));
        ev(1'b1);
        look(4, 16'(sp1 + sp2), "offset set point");
        wr(esrd_pkg::A_CONFIG, cfg(esrd_pkg::F_SP2, 1'b0, esrd_pkg::S_SINGLE, 1'b0, 1'b0));
        cyc(2);
        look(4, sp1, "single source");
        ev(1'b0);
        $display("test second set point done");

        // Tuning results land in whichever gain set is selected at that moment.
        wr(esrd_pkg::A_CONFIG, cfg(esrd_pkg::F_GAIN, 1'b0, esrd_pkg::S_DUAL, 1'b0, 1'b0));
        ev(1'b1);
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            tpb <= 16'($urandom);
            tti <= 16'($urandom);
            ttd <= 16'($urandom);
            tune <= 1'b1;
            @(posedge sys_clk);
            tune <= 1'b0;
            cyc(2);
            rd(4'(esrd_pkg::A_GAIN0 + 4'(3 - 3 * k)), tpb, "tuned band");
            rd(4'(esrd_pkg::A_GAIN0 + 4'(4 - 3 * k)), tti, "tuned integral");
            rd(4'(esrd_pkg::A_GAIN0 + 4'(5 - 3 * k)), ttd, "tuned derivative");
            look(5, tpb, "tuned band in use");
            ev(1'b0);
        end
        $display("test tuning done");

        // Ramp: reload to the process value, a visible slew, and zero rate turning it off.
        pv <= 16'h0100;
        wr(esrd_pkg::A_CONFIG, cfg(esrd_pkg::F_NONE, 1'b0, esrd_pkg::S_MIN, 1'b0, 1'b0));
        wr(esrd_pkg::A_RATE, 16'h0001);
        wr(esrd_pkg::A_SP1, 16'h0400);
        cyc(1);
        look(4, 16'h0100, "ramp start");
        cyc(40);
        look(4, 16'h0100, "slow ramp");
        pv <= 16'h0200;
        wr(esrd_pkg::A_RATE, 16'h0002);
        cyc(1);
        look(4, 16'h0200, "rate reload");
        wr(esrd_pkg::A_RATE, 16'hea60);
        cyc(60);
        look(9, 16'h1, "ramp moving");
        wr(esrd_pkg::A_RATE, 16'h0000);
        cyc(2);
        look(4, 16'h0400, "ramp off");
        wr(esrd_pkg::A_CONFIG, cfg(esrd_pkg::F_NONE, 1'b0, esrd_pkg::S_HOUR, 1'b0, 1'b0));
        wr(esrd_pkg::A_RATE, 16'hea60);
        cyc(60);
        look(4, 16'h0200, "hourly ramp");
        $display("test ramp done");

        // Dwell on alarm 1, with the duration lengthened while counting.
        c1 <= 1'b0;
        c2 <= 1'b0;
        pv <= 16'h0000;
        wr(esrd_pkg::A_DWELL, 16'h0003);
        wr(esrd_pkg::A_SP1, 16'h0050);
        wr(esrd_pkg::A_CONFIG, cfg(esrd_pkg::F_CLR12, 1'b0, esrd_pkg::S_SINGLE, 1'b1, 1'b0));
        ev(1'b1);
        ev(1'b0);
        look(3, 16'h0, "alarms cleared");
        pv <= 16'h0050;
        cyc(10);
        wr(esrd_pkg::A_DWELL, 16'h0005);
        cyc(18);
        look(3, 16'h0, "dwell still counting");
        cyc(22);
        look(3, 16'h1, "dwell expired");
        pv <= 16'h0000;
        cyc(20);
        look(3, 16'h1, "dwell held");
        ev(1'b1);
        look(3, 16'h0, "dwell reset");
        ev(1'b0);
        look(3, 16'h0, "dwell stays reset");
        $display("test dwell done");

        // Both alarms on the dwell timer is a configuration error.
        wr(esrd_pkg::A_CONFIG, cfg(esrd_pkg::F_NONE, 1'b0, esrd_pkg::S_SINGLE, 1'b1, 1'b1));
        cyc(2);
        look(8, 16'h1, "config error");
        wr(esrd_pkg::A_CONFIG, cfg(esrd_pkg::F_DIS1, 1'b0, esrd_pkg::S_SINGLE, 1'b0, 1'b0));
        cyc(2);
        look(8, 16'h0, "config error gone");
        $display("test config error done");

        // A short clean pulse on the pin must not reach the outputs.
        bouncy <= 1'b0;
        want <= 1'b1;
        cyc(2);
        want <= 1'b0;
        cyc(12);
        look(1, mv1, "glitch ignored");
        $display("test glitch done");
        wrap_up();
    end
endmodule
